// ==== hs_homing_top.sv ====
// Homing sequencer top: register port, start sources, method decode, phase machine.
// Assumes encoder position, i2t, torque and fieldbus start arrive on ref_clk;
// switch, index and start pins are asynchronous and are synchronised here.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module hs_homing_top
  import hs_pkg::*;
(
  input wire logic ref_clk, // 50 MHz clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic [7:0] addr, // Register byte address.
  input wire logic [31:0] wdata, // Write data.
  input wire logic wr_stb, // Write strobe.
  input wire logic rd_stb, // Read strobe.
  output logic [31:0] rdata, // Read data, cycle after the strobe.
  input wire logic fb_start, // Fieldbus start pulse.
  input wire logic fb_canopen, // Fieldbus start came over CANopen.
  input wire logic drv_enable, // Drive enable level.
  input wire logic din_start_pin, // Digital start input pin.
  input wire logic lim_pos_pin, // Positive limit switch pin.
  input wire logic lim_neg_pin, // Negative limit switch pin.
  input wire logic ref_sw_pin, // Reference switch pin.
  input wire logic idx_pin, // Encoder index pin.
  input wire logic idx_known, // Index position already known.
  input wire logic [31:0] enc_pos, // Actual position.
  input wire logic [15:0] i2t, // Motor i2t value.
  input wire logic [15:0] torque, // Signed actual torque.
  output logic [15:0] speed_cmd, // Signed speed setpoint.
  output logic busy, // Homing run in progress.
  output logic homed, // Homing done status.
  output logic dout_homed, // Digital output carrying homing done.
  output logic home_set, // Pulse: take home_pos as zero.
  output logic [31:0] home_pos, // Found home position.
  output logic irq // Level interrupt.
);
  // ========================================================================
  // Pin synchronisers.
  localparam int NS = 5;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sy1_r;
  logic [NS-1:0] sy2_r;
  logic [NS-1:0] prev_r;
  assign pin_raw = {idx_pin, ref_sw_pin, lim_neg_pin, lim_pos_pin, din_start_pin};
  for (genvar i = 0; i < NS; i++) begin : g_sync
    always_ff @(posedge ref_clk) begin
      if (!nrst) begin
        sy1_r[i] <= 1'b0;
        sy2_r[i] <= 1'b0;
        prev_r[i] <= 1'b0;
      end else begin
        sy1_r[i] <= pin_raw[i];
        sy2_r[i] <= sy1_r[i];
        prev_r[i] <= sy2_r[i];
      end
    end
  end
  logic din_rise;
  logic lim_pos;
  logic lim_neg;
  logic ref_sw;
  logic idx_rise;
  assign din_rise = sy2_r[0] & ~prev_r[0];
  assign lim_pos = sy2_r[1];
  assign lim_neg = sy2_r[2];
  assign ref_sw = sy2_r[3];
  assign idx_rise = sy2_r[4] & ~prev_r[4];

  // ========================================================================
  // Register file.
  logic [3:0] ctrl_r;
  logic [7:0] method_r;
  logic [15:0] spd_srch_r;
  logic [15:0] spd_crwl_r;
  logic [15:0] spd_zero_r;
  logic [15:0] accel_r;
  logic [15:0] torq_cmp_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [31:0] rd_val;
  logic [31:0] rdata_r;
  logic irq_r;
  logic done_r;
  logic busy_r;
  hs_state_t state_r;
  hs_state_t state_nxt;
  hs_ramp_if #(.W(SPD_W)) rif();
  logic [31:0] home_pos_r;
  logic sw_start;
  // Write decode.
  assign sw_start = wr_stb && (addr == A_CTRL) && wdata[CB_START];
  assign irq_clr = (wr_stb && (addr == A_IRQ_STAT)) ? wdata[1:0] : 2'h0;
  // Configuration registers.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RST;
      method_r <= METHOD_RST;
      spd_srch_r <= SPD_SRCH_RST;
      spd_crwl_r <= SPD_CRWL_RST;
      spd_zero_r <= SPD_ZERO_RST;
      accel_r <= ACCEL_RST;
      torq_cmp_r <= TORQ_CMP_RST;
      irq_mask_r <= IRQ_RST;
    end else if (wr_stb) begin
      if (addr == A_CTRL) ctrl_r <= wdata[3:0];
      if (addr == A_METHOD) method_r <= wdata[7:0];
      if (addr == A_SPD_SRCH) spd_srch_r <= wdata[15:0];
      if (addr == A_SPD_CRWL) spd_crwl_r <= wdata[15:0];
      if (addr == A_SPD_ZERO) spd_zero_r <= wdata[15:0];
      if (addr == A_ACCEL) accel_r <= wdata[15:0];
      if (addr == A_TORQ_CMP) torq_cmp_r <= wdata[15:0];
      if (addr == A_IRQ_MASK) irq_mask_r <= wdata[1:0];
    end
  end
  // Read select; unmapped addresses read zero.
  assign rd_val = (addr == A_CTRL) ? {28'h0, ctrl_r} :
                  (addr == A_METHOD) ? {24'h0, method_r} :
                  (addr == A_SPD_SRCH) ? {16'h0, spd_srch_r} :
                  (addr == A_SPD_CRWL) ? {16'h0, spd_crwl_r} :
                  (addr == A_SPD_ZERO) ? {16'h0, spd_zero_r} :
                  (addr == A_ACCEL) ? {16'h0, accel_r} :
                  (addr == A_TORQ_CMP) ? {16'h0, torq_cmp_r} :
                  (addr == A_STATUS) ? {25'h0, state_r, 2'h0, busy_r, done_r} :
                  (addr == A_IRQ_STAT) ? {30'h0, irq_stat_r} :
                  (addr == A_IRQ_MASK) ? {30'h0, irq_mask_r} :
                  (addr == A_HOME_POS) ? home_pos_r : 32'h0;
  // Read data, sticky events with set winning over clear, interrupt level.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_r <= 32'h0;
      irq_stat_r <= IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      rdata_r <= rd_stb ? rd_val : 32'h0;
      irq_stat_r <= irq_set | (irq_stat_r & ~irq_clr);
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ========================================================================
  // Method decode.
  logic dec_ok;
  logic [1:0] dec_kind;
  logic dec_idx;
  logic dec_eor;
  logic dec_pos;
  always_comb begin
    {dec_ok, dec_kind, dec_idx, dec_eor, dec_pos} = {1'b1, K_STOP, 3'b000};
    unique case (method_r)
      M_STOP_P: {dec_kind, dec_idx, dec_eor, dec_pos} = {K_STOP, 3'b001};
      M_STOP_N: {dec_kind, dec_idx, dec_eor, dec_pos} = {K_STOP, 3'b000};
      M_STIX_N: {dec_kind, dec_idx, dec_eor, dec_pos} = {K_STOP, 3'b100};
      M_STIX_P: {dec_kind, dec_idx, dec_eor, dec_pos} = {K_STOP, 3'b101};
      M_LIM_N: {dec_kind, dec_idx, dec_eor, dec_pos} = {K_LIM, 3'b000};
      M_LIM_P: {dec_kind, dec_idx, dec_eor, dec_pos} = {K_LIM, 3'b001};
      M_LMIX_N: {dec_kind, dec_idx, dec_eor, dec_pos} = {K_LIM, 3'b100};
      M_LMIX_P: {dec_kind, dec_idx, dec_eor, dec_pos} = {K_LIM, 3'b101};
      M_REF_P: {dec_kind, dec_idx, dec_eor, dec_pos} = {K_REF, 3'b001};
      M_REF_N: {dec_kind, dec_idx, dec_eor, dec_pos} = {K_REF, 3'b000};
      M_EOR_P: {dec_kind, dec_idx, dec_eor, dec_pos} = {K_REF, 3'b011};
      M_EOR_N: {dec_kind, dec_idx, dec_eor, dec_pos} = {K_REF, 3'b010};
      M_RFIX_P: {dec_kind, dec_idx, dec_eor, dec_pos} = {K_REF, 3'b101};
      M_RFIX_N: {dec_kind, dec_idx, dec_eor, dec_pos} = {K_REF, 3'b100};
      M_HERE: {dec_kind, dec_idx, dec_eor, dec_pos} = {K_HERE, 3'b000};
      default: dec_ok = 1'b0;
    endcase
  end

  // ========================================================================
  // Start sources and reference detection.
  logic en_prev_r;
  logic auto_rise;
  logic start_req;
  logic dir_r;
  logic [1:0] sel_r;
  logic sw_prev_r;
  logic sw_now;
  logic sw_fall;
  logic lim_ahead;
  logic [15:0] base_r;
  logic [15:0] tq_abs;
  logic [17:0] i2t_x2;
  logic [17:0] base_x3;
  logic stop_hit;
  logic idx_go;
  logic gz_dir;
  logic canopen_r;
  hs_state_t fin_st;
  assign auto_rise = ctrl_r[CB_AUTO] && drv_enable && !en_prev_r;
  assign start_req = fb_start || sw_start || din_rise || auto_rise;
  assign lim_ahead = dir_r ? lim_pos : lim_neg;
  assign sw_now = (sel_r == K_REF) ? ref_sw : (sel_r == K_LIM) ? lim_neg : lim_pos;
  assign sw_fall = sw_prev_r && !sw_now;
  assign tq_abs = torque[15] ? 16'(16'h0 - torque) : torque;
  assign i2t_x2 = {1'b0, i2t, 1'b0};
  assign base_x3 = {2'h0, base_r} + {1'b0, base_r, 1'b0};
  assign stop_hit = ctrl_r[CB_TORQ] ? (tq_abs >= torq_cmp_r) : (i2t_x2 >= base_x3);
  assign idx_go = dec_idx && !idx_known;
  assign gz_dir = $signed(home_pos_r) > $signed(enc_pos);
  assign fin_st = (ctrl_r[CB_GOZERO] && !canopen_r) ? ST_GOZERO : ST_FINISH;

  // ========================================================================
  // Phase machine.
  logic dir_nxt;
  logic [1:0] sel_nxt;
  logic [31:0] home_nxt;
  logic [15:0] base_nxt;
  logic can_nxt;
  logic done_nxt;
  logic hset_nxt;
  logic home_set_r;
  logic dout_r;
  always_comb begin
    state_nxt = state_r;
    dir_nxt = dir_r;
    sel_nxt = sel_r;
    home_nxt = home_pos_r;
    base_nxt = base_r;
    can_nxt = canopen_r;
    done_nxt = done_r;
    hset_nxt = 1'b0;
    irq_set = 2'h0;
    unique case (state_r)
      ST_IDLE: begin
        if (start_req && !dec_ok) begin
          irq_set[IB_ERR] = 1'b1;
        end else if (start_req) begin
          done_nxt = 1'b0;
          can_nxt = fb_start && fb_canopen;
          base_nxt = i2t;
          dir_nxt = dec_pos;
          if (dec_kind == K_HERE) begin
            home_nxt = enc_pos;
            state_nxt = ST_FINISH;
          end else begin
            state_nxt = dec_eor ? ST_EOR : ST_SEARCH;
          end
        end
      end
      ST_EOR: begin
        if (lim_ahead || stop_hit) begin
          dir_nxt = !dir_r;
          state_nxt = ST_SEARCH;
        end
      end
      ST_SEARCH: begin
        if (dec_kind == K_STOP && stop_hit) begin
          home_nxt = enc_pos;
          dir_nxt = !dir_r;
          state_nxt = idx_go ? ST_INDEX : fin_st;
        end else if (dec_kind == K_LIM && lim_ahead) begin
          sel_nxt = dir_r ? K_STOP : K_LIM;
          dir_nxt = !dir_r;
          state_nxt = ST_CRAWL;
        end else if (dec_kind == K_REF && ref_sw) begin
          sel_nxt = K_REF;
          dir_nxt = !dir_r;
          state_nxt = ST_CRAWL;
        end else if (dec_kind == K_REF && lim_ahead) begin
          dir_nxt = !dir_r;
        end
      end
      ST_CRAWL: begin
        if (sw_fall) begin
          home_nxt = enc_pos;
          state_nxt = idx_go ? ST_INDEX : fin_st;
        end
      end
      ST_INDEX: begin
        if (idx_rise) begin
          home_nxt = enc_pos;
          state_nxt = fin_st;
        end
      end
      ST_GOZERO: begin
        dir_nxt = gz_dir;
        if (enc_pos == home_pos_r) state_nxt = ST_FINISH;
      end
      ST_FINISH: begin
        if (rif.at_zero) begin
          done_nxt = 1'b1;
          hset_nxt = 1'b1;
          irq_set[IB_DONE] = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end
  // Phase state and captured values.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      dir_r <= 1'b0;
      sel_r <= K_STOP;
      home_pos_r <= 32'h0;
      base_r <= 16'h0;
      canopen_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
      home_set_r <= 1'b0;
      dout_r <= 1'b0;
      en_prev_r <= 1'b0;
      sw_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      dir_r <= dir_nxt;
      sel_r <= sel_nxt;
      home_pos_r <= home_nxt;
      base_r <= base_nxt;
      canopen_r <= can_nxt;
      done_r <= done_nxt;
      busy_r <= (state_nxt != ST_IDLE);
      home_set_r <= hset_nxt;
      dout_r <= done_r && ctrl_r[CB_DOUT];
      en_prev_r <= drv_enable;
      sw_prev_r <= sw_now;
    end
  end

  // ========================================================================
  // Speed ramp.
  logic [5:0] tick_cnt_r;
  logic tick_r;
  logic [15:0] spd_mag;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tick_cnt_r <= 6'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == 6'(RAMP_TICK_CYC - 1));
      tick_cnt_r <= (tick_cnt_r == 6'(RAMP_TICK_CYC - 1)) ? 6'h0 : 6'(tick_cnt_r + 6'h1);
    end
  end
  // Phase speed select; magnitudes are not limited, so one of half range or more flips the target sign.
  assign spd_mag = (state_r == ST_EOR || state_r == ST_SEARCH) ? spd_srch_r :
                   (state_r == ST_CRAWL || state_r == ST_INDEX) ? spd_crwl_r :
                   (state_r == ST_GOZERO) ? spd_zero_r : 16'h0;
  assign rif.target = dir_r ? spd_mag : 16'(16'h0 - spd_mag);
  assign rif.step = accel_r;
  assign rif.tick = tick_r;
  hs_ramp #(.W(SPD_W)) u_ramp (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .rif(rif.rmp)
  );

  // Outputs.
  assign rdata = rdata_r;
  assign speed_cmd = rif.speed;
  assign busy = busy_r;
  assign homed = done_r;
  assign dout_homed = dout_r;
  assign home_set = home_set_r;
  assign home_pos = home_pos_r;
  assign irq = irq_r;

  // ========================================================================
  // Checks.
  chk_done_clear_start: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_r == ST_IDLE && start_req && dec_ok |=> !homed && busy)
    else $error("Done not cleared at run start.");
  chk_done_on_finish: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_r == ST_FINISH && rif.at_zero |=> homed && home_set ##1 !home_set)
    else $error("Done not set at finish.");
  chk_canopen_no_move: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_r == ST_GOZERO |-> !canopen_r)
    else $error("Move to home after CANopen start.");
  chk_here_no_motion: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_r == ST_IDLE && start_req && method_r == M_HERE
    |=> state_r == ST_FINISH && home_pos_r == $past(enc_pos))
    else $error("Method 34 did not take current position.");
  chk_crawl_edge_home: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_r == ST_CRAWL && sw_fall |=> home_pos_r == $past(enc_pos) && state_r != ST_CRAWL)
    else $error("Switch falling edge not taken as home.");
  chk_ref_reverse: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_r == ST_SEARCH && dec_kind == K_REF && !ref_sw && lim_ahead |=> dir_r != $past(dir_r))
    else $error("Reference search did not reverse at limit.");
  chk_auto_start: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_r == ST_IDLE && auto_rise && dec_ok |=> state_r != ST_IDLE)
    else $error("Auto start on enable missed.");
  chk_dout_route: assert property (@(posedge ref_clk) disable iff (!nrst)
    ##1 dout_homed == ($past(done_r) && $past(ctrl_r[CB_DOUT])))
    else $error("Done output routing wrong.");
  chk_index_skip: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_r == ST_CRAWL && sw_fall && idx_known |=> state_r != ST_INDEX)
    else $error("Index search not skipped.");
endmodule // hs_homing_top

// ==== hs_pkg.sv ====
// Constants, register map, method codes and state type of the homing sequencer.
// Assumes a single 50 MHz clock and a plain strobe register port.
// ==========================================================================
// How it works
// - Start comes from fieldbus, software register write or a digital input pin.
// - With auto enabled, a rising drive enable starts a homing run.
// - Phases run in order: search, crawl for switch methods, then optional move to home.
// - Search moves at search speed until the selected reference signal appears.
// - Crawl moves slowly back off the switch to find its exact edge.
// - Index methods then take the encoder index pulse as finer reference.
// - With go-to-zero set the run ends by moving to the home position.
// - A run started over CANopen never makes the final move to home.
// - A successful run sets the homing-done status bit.
// - The homing-done status can be routed to a digital output.
// - Method numbers decode to stop, limit, reference, end-of-range and index kinds.
// - Index search is skipped when the index position is already known.
// - Each movement uses programmable speeds and a programmable ramp.
// - Limit switches or a mechanical stop serve as reference, per method.
// - For limit switch methods the switch falling edge is the home position.
// - A stop is seen at a 50 percent i2t rise or at a comparison torque.
// - Method 34 makes no motion and takes the current position as home.
// - Reference search reverses direction when the limit switch ahead is reached.
package hs_pkg;
  // ========================================================================
  // Register offsets.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_METHOD = 8'h04;
  localparam logic [7:0] A_SPD_SRCH = 8'h08;
  localparam logic [7:0] A_SPD_CRWL = 8'h0C;
  localparam logic [7:0] A_SPD_ZERO = 8'h10;
  localparam logic [7:0] A_ACCEL = 8'h14;
  localparam logic [7:0] A_TORQ_CMP = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;
  localparam logic [7:0] A_IRQ_STAT = 8'h20;
  localparam logic [7:0] A_IRQ_MASK = 8'h24;
  localparam logic [7:0] A_HOME_POS = 8'h28;
  // Field positions.
  localparam int CB_AUTO = 0;
  localparam int CB_GOZERO = 1;
  localparam int CB_TORQ = 2;
  localparam int CB_DOUT = 3;
  localparam int CB_START = 8;
  localparam int IB_DONE = 0;
  localparam int IB_ERR = 1;
  localparam int SB_DONE = 0;
  localparam int SB_BUSY = 1;
  localparam int SB_PHASE = 4;
  // Reset values.
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [7:0] METHOD_RST = 8'h22;
  localparam logic [15:0] SPD_SRCH_RST = 16'h0100;
  localparam logic [15:0] SPD_CRWL_RST = 16'h0020;
  localparam logic [15:0] SPD_ZERO_RST = 16'h0040;
  localparam logic [15:0] ACCEL_RST = 16'h0010;
  localparam logic [15:0] TORQ_CMP_RST = 16'h0400;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // Timing: ramp update period.
  localparam int CLK_NS = 20;
  localparam int RAMP_TICK_NS = 1000;
  localparam int RAMP_TICK_CYC = (RAMP_TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int SPD_W = 16;
  // Homing method codes as signed bytes.
  localparam logic [7:0] M_STOP_P = 8'hEE;
  localparam logic [7:0] M_STOP_N = 8'hEF;
  localparam logic [7:0] M_STIX_N = 8'hFF;
  localparam logic [7:0] M_STIX_P = 8'hFE;
  localparam logic [7:0] M_LIM_N = 8'h11;
  localparam logic [7:0] M_LIM_P = 8'h12;
  localparam logic [7:0] M_LMIX_N = 8'h01;
  localparam logic [7:0] M_LMIX_P = 8'h02;
  localparam logic [7:0] M_REF_P = 8'h17;
  localparam logic [7:0] M_REF_N = 8'h1B;
  localparam logic [7:0] M_EOR_P = 8'hE9;
  localparam logic [7:0] M_EOR_N = 8'hE5;
  localparam logic [7:0] M_RFIX_P = 8'h07;
  localparam logic [7:0] M_RFIX_N = 8'h0B;
  localparam logic [7:0] M_HERE = 8'h22;
  // Reference kinds and tracked switch selects.
  localparam logic [1:0] K_STOP = 2'h0;
  localparam logic [1:0] K_LIM = 2'h1;
  localparam logic [1:0] K_REF = 2'h2;
  localparam logic [1:0] K_HERE = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EOR = 3'b001,
    ST_SEARCH = 3'b010,
    ST_CRAWL = 3'b011,
    ST_INDEX = 3'b100,
    ST_GOZERO = 3'b101,
    ST_FINISH = 3'b110
  } hs_state_t;
endpackage

// ==== hs_plant.sv ====
// Axis model: position, limit and reference switches, stop and index.
// Assumes speed_cmd on ref_clk; the axis moves one count a cycle in its sign.
`timescale 1ns/1ps
module hs_plant (
  input wire logic ref_clk, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire logic [15:0] speed_cmd, // Speed setpoint.
  output logic [31:0] enc_pos, // Position.
  output logic [15:0] i2t, // Motor i2t.
  output logic [15:0] torque, // Signed actual torque.
  output logic lim_pos_pin, // Upper limit.
  output logic lim_neg_pin, // Lower limit.
  output logic ref_sw_pin, // Reference switch.
  output logic idx_pin // Index pulse.
);
  // ======
  // Next position; the mechanical stops hold it within plus or minus 400.
  int p;
  int p_nxt;
  logic push;
  assign p = $signed(enc_pos);
  assign p_nxt = p + (speed_cmd[15] ? -1 : int'(|speed_cmd));
  assign push = p_nxt > 400 || p_nxt < -400;
  always_ff @(posedge ref_clk) begin
    if (!nrst) enc_pos <= 32'h0;
    else if (!push) enc_pos <= p_nxt;
  end
  // Pushing into a stop doubles i2t.
  assign i2t = push ? 16'h0200 : 16'h0100;
  // Pushing into a stop raises the torque magnitude, signed by direction.
  assign torque = !push ? 16'h0000 : speed_cmd[15] ? 16'hFB00 : 16'h0500;
  assign lim_pos_pin = p >= 300;
  assign lim_neg_pin = p <= -300;
  assign ref_sw_pin = p >= 100 && p <= 140;
  assign idx_pin = enc_pos[3:0] == 4'h0;
endmodule // hs_plant

// ==== hs_ramp.sv ====
// Speed ramp generator for the homing movements.
// Assumes the tick is a one-cycle enable pulse on the same clock.
`timescale 1ns/1ps
module hs_ramp
  import hs_pkg::*;
#(
  parameter int W = SPD_W // Speed width.
) (
  input wire logic ref_clk, // System clock.
  input wire logic nrst, // Synchronous reset, active low.
  hs_ramp_if.rmp rif // Ramp control.
);
  if (W < 4) begin : g_bad_w
    $error("hs_ramp needs W of at least 4.");
  end
  logic signed [W-1:0] spd_r;
  logic signed [W-1:0] spd_nxt;
  logic signed [W:0] diff;
  logic signed [W:0] stp;
  // Step toward the target without overshoot.
  // Both operands are sign-extended by hand so a negative target stays negative.
  assign diff = {rif.target[W-1], rif.target} - {spd_r[W-1], spd_r};
  assign stp = {1'b0, rif.step};
  always_comb begin
    spd_nxt = spd_r;
    if (rif.tick) begin
      if (diff > stp) begin
        spd_nxt = W'(spd_r + rif.step);
      end else if (diff < -stp) begin
        spd_nxt = W'(spd_r - rif.step);
      end else begin
        spd_nxt = rif.target;
      end
    end
  end
  // Speed register.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      spd_r <= '0;
    end else begin
      spd_r <= spd_nxt;
    end
  end
  assign rif.speed = spd_r;
  assign rif.at_zero = (spd_r == '0);
  // Speed only moves on a tick.
  chk_ramp_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    !rif.tick |=> rif.speed == $past(rif.speed))
    else $error("Ramp speed moved without a tick.");
  // Each tick changes the speed by at most one step.
  chk_ramp_step: assert property (@(posedge ref_clk) disable iff (!nrst)
    rif.tick && (rif.step < 16'h4000) |=>
    (($signed(rif.speed) - $signed($past(rif.speed)) <= $signed({1'b0, $past(rif.step)})) &&
     ($signed($past(rif.speed)) - $signed(rif.speed) <= $signed({1'b0, $past(rif.step)}))))
    else $error("Ramp step exceeded.");
endmodule // hs_ramp

// ==== hs_ramp_if.sv ====
// Interface between the sequencer and its speed ramp.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface hs_ramp_if #(parameter int W = 16);
  logic signed [W-1:0] target; // Wanted signed speed.
  logic [W-1:0] step; // Speed change per tick.
  logic tick; // Ramp update enable.
  logic signed [W-1:0] speed; // Present ramped speed.
  logic at_zero; // Ramped speed is zero.
  modport ctl(output target, step, tick, input speed, at_zero);
  modport rmp(input target, step, tick, output speed, at_zero);
endinterface

// ==== tb.sv ====
// Bench of the homing sequencer: registers, all methods, starts, interrupt.
// Assumes hs_plant closes the loop from speed_cmd back to the pins.
`timescale 1ns/1ps
module tb;
  import hs_pkg::*;
  logic ref_clk, nrst, wr_stb, rd_stb, fb_start, fb_canopen, drv_enable;
  logic din_start_pin, idx_known, busy, homed, dout_homed, irq, home_set;
  logic lim_pos_pin, lim_neg_pin, ref_sw_pin, idx_pin;
  logic [7:0] addr;
  logic [15:0] i2t, speed_cmd, torque;
  logic [31:0] wdata, rdata, enc_pos, home_pos;
  logic [7:0] mtab [15] = '{8'h22, 8'hEE, 8'hEF, 8'hFF, 8'hFE, 8'h11, 8'h12, 8'h01,
    8'h02, 8'h17, 8'h1B, 8'hE9, 8'hE5, 8'h07, 8'h0B};
  int err_count = 0;
  int n_tests = 0;
  hs_homing_top hs_homing_top_i (.ref_clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .fb_start, .fb_canopen, .drv_enable, .din_start_pin, .lim_pos_pin,
    .lim_neg_pin, .ref_sw_pin, .idx_pin, .idx_known, .enc_pos, .i2t, .torque,
    .speed_cmd, .busy, .homed, .dout_homed, .home_set, .home_pos, .irq);
  hs_plant hs_plant_i (.ref_clk, .nrst, .speed_cmd, .enc_pos, .i2t, .torque, .lim_pos_pin,
    .lim_neg_pin, .ref_sw_pin, .idx_pin);
  // ======
  // Clock, watchdog and shared tasks.
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    end_of_test();
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // A final move to home is expected unless it is off or the start came over CANopen.
  function automatic logic exp_gozero(input logic g, input int s, input logic c);
    return g && !(s == 1 && c);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic end_of_test();
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ======
  // Main sequence: defaults, every method from a random source, bad method.
  initial begin
    logic gz;
    logic cn;
    logic tq;
    int src;
    int d;
    {nrst, wr_stb, rd_stb, fb_start, fb_canopen, drv_enable} = '0;
    {din_start_pin, idx_known, addr, wdata} = '0;
    void'($urandom(32'h90F5));
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(A_METHOD, 32'h22);
    rd(A_SPD_SRCH, 32'h0100);
    rd(A_ACCEL, 32'h10);
    rd(8'hFC, 32'h0);
    wr(A_ACCEL, 32'h0100);
    wr(A_IRQ_MASK, 32'h3);
    for (int i = 0; i < 15; i++) begin
      gz = 1'($urandom_range(1));
      cn = 1'($urandom_range(1));
      tq = 1'($urandom_range(1));
      src = $urandom_range(3);
      wr(A_METHOD, {24'h0, mtab[i]});
      drv_enable <= 1'b0;
      idx_known <= 1'($urandom_range(1));
      wr(A_CTRL, 32'h8 | {29'h0, tq, gz, src == 3});
      @(posedge ref_clk);
      fb_start <= src == 1;
      fb_canopen <= cn;
      din_start_pin <= src == 2;
      drv_enable <= 1'b1;
      if (src == 0) wr(A_CTRL, 32'h0108 | {29'h0, tq, gz, 1'b0});
      else @(posedge ref_clk);
      fb_start <= 1'b0;
      #1;
      for (int k = 0; k < 20 && busy !== 1'b1; k++) @(posedge ref_clk) #1;
      chk(busy, 1'b1);
      chk(homed, 1'b0);
      for (int k = 0; k < 8000 && busy !== 1'b0; k++) @(posedge ref_clk) #1;
      chk(home_set, 1'b1);
      @(posedge ref_clk) #1;
      din_start_pin <= 1'b0;
      chk(busy, 1'b0);
      chk(homed, 1'b1);
      chk(dout_homed, 1'b1);
      d = $signed(enc_pos - home_pos);
      if (exp_gozero(gz, src, cn)) chk(d < 64 && d > -64, 1'b1);
      if (i == 0) chk(home_pos, enc_pos);
    end
    wr(A_IRQ_STAT, 32'h3);
    wr(A_METHOD, 32'h05);
    wr(A_CTRL, 32'h0108);
    repeat (2) @(posedge ref_clk);
    #1 chk(irq, 1'b1);
    rd(A_IRQ_STAT, 32'h2);
    chk(homed, 1'b1);
    wr(A_IRQ_MASK, 32'h1);
    @(posedge ref_clk) #1 chk(irq, 1'b0);
    wr(A_IRQ_STAT, 32'h2);
    rd(A_IRQ_STAT, 32'h0);
    end_of_test();
  end
endmodule // tb
